/* irq_src_defs.svh */
`ifndef IRQ_SRC_DEFS_SVH
`define IRQ_SRC_DEFS_SVH
// How it works
// - Priority register four holds high/low priority for capture/compare 5, 4, 3.
// - Priority register five holds priority for timer 6, timer 5 and timer 4.
// - External pins trigger on rising edge when select is 1, falling when 0.
// - A valid pin edge sets that pin's flag.
// - A cleared pin enable suppresses that pin's request.
// - Pin interrupts enabled before entry wake the core from Idle or Sleep.
// - After wake-up, vector only when global enable is set.
// - Pins 1 and 2 take priority from two bits of control register three.
// - Pin 0 has no priority bit and is always high priority.
// - In 8-bit mode timer zero rollover FF to 00 sets its flag.
// - In 16-bit mode rollover FFFF to 0000 sets the timer zero flag.
// - Timer zero request gated by its enable, priority by its priority bit.
// - Enabled change on port B bits 7:4 sets the port change flag.
// - Port change request gated by its enable, priority by its priority bit.
// - On entry, push return address and copy working, status, bank registers.

// Register offsets on the plain register port.
`define IRQ_OFS_MAIN 4'h0
`define IRQ_OFS_EDGE_PRIO 4'h1
`define IRQ_OFS_EXT_PINS 4'h2
`define IRQ_OFS_PIN_EN 4'h3
`define IRQ_OFS_PRIO4 4'h4
`define IRQ_OFS_PRIO5 4'h5
`define IRQ_OFS_CAUSE_PRIO 4'h6
`define IRQ_OFS_TMR_LO 4'h7
`define IRQ_OFS_TMR_HI 4'h8
`define IRQ_OFS_TMR_CTL 4'h9
`define IRQ_OFS_CTX_W 4'hA
`define IRQ_OFS_CTX_S 4'hB
`define IRQ_OFS_CTX_B 4'hC

// Main control register fields.
`define IRQ_MAIN_GLOBAL_EN 7
`define IRQ_MAIN_PERI_EN 6
`define IRQ_MAIN_T0E 5
`define IRQ_MAIN_X0E 4
`define IRQ_MAIN_PCE 3
`define IRQ_MAIN_T0F 2
`define IRQ_MAIN_X0F 1
`define IRQ_MAIN_PCF 0
// Edge and priority register fields.
`define IRQ_EP_EDGE0 6
`define IRQ_EP_EDGE1 5
`define IRQ_EP_EDGE2 4
`define IRQ_EP_T0P 2
`define IRQ_EP_PCP 0
// External pin register fields.
`define IRQ_XP_X2P 7
`define IRQ_XP_X1P 6
`define IRQ_XP_X2E 4
`define IRQ_XP_X1E 3
`define IRQ_XP_X2F 1
`define IRQ_XP_X1F 0
// Priority enable bit in the reset-cause register.
`define IRQ_RC_PRIO_EN 7

// Reset values and write masks.
`define IRQ_RST_MAIN 8'h00
`define IRQ_RST_EDGE_PRIO 8'hF5
`define IRQ_RST_EXT_PINS 8'hC0
`define IRQ_RST_PIN_EN 8'hF0
`define IRQ_RST_PRIO 8'h00
`define IRQ_MASK_EDGE_PRIO 8'hF5
`define IRQ_MASK_EXT_PINS 8'hDB
`define IRQ_MASK_PIN_EN 8'hF0
`define IRQ_MASK_PRIO 8'h07
`define IRQ_MASK_CAUSE_PRIO 8'h80
`endif

/* irq_src_pkg.sv */
package irq_src_pkg;
    typedef enum logic [1:0] {
        RUN,
        SERVE_LOW,
        SERVE_HIGH
    } svc_t;

    typedef struct packed {
        logic [7:0] working;
        logic [7:0] status;
        logic [7:0] bank;
    } ctx_t;

    typedef struct packed {
        logic [7:0] main;
        logic [7:0] edgePrio;
        logic [7:0] extPins;
        logic [7:0] pinEn;
        logic [7:0] prio4;
        logic [7:0] prio5;
        logic [7:0] causePrio;
        logic [15:0] timerZero;
        logic timerWide;
        logic [2:0] pinPrev;
        logic [3:0] portPrev;
        logic asleep;
        logic [2:0] enAtSleep;
        svc_t svc;
        logic [20:0] retPc;
        logic pushStrobe;
        ctx_t fastCtx;
        logic [7:0] rdData;
    } state_t;
endpackage

/* irq_sources.sv */
`include "irq_src_defs.svh"

module irq_sources #(
    parameter int PC_W = 21
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic [7:0] port_b_pins,
    input wire logic timerTick,
    input wire logic sleepEnter,
    input wire logic [PC_W-1:0] corePc,
    input wire irq_src_pkg::ctx_t coreCtx,
    input wire logic retFromIrq,
    output logic wakeUp,
    output logic vectorHigh,
    output logic vectorLow,
    output logic [PC_W-1:0] stackPushPc,
    output logic stackPush,
    output logic highReq,
    output logic lowReq,
    output logic [2:0] capcmpPrio,
    output logic [2:0] timerPrio
);
    irq_src_pkg::state_t q_ff;
    irq_src_pkg::state_t nxt_q;
    logic [2:0] pinNow;
    logic [2:0] edgeSel;
    logic [2:0] pinHit;
    logic [3:0] portHit;
    logic t0Roll;
    logic [2:0] xFlag;
    logic [2:0] xEn;
    logic [2:0] xPrio;
    logic [2:0] xReq;
    logic t0Req;
    logic pcReq;
    logic prioOn;
    logic globalEn;
    logic periEn;
    logic anyHigh;
    logic anyLow;
    logic takeHigh;
    logic takeLow;

    // Pin views and event detection from the previous-cycle samples.
    assign pinNow = port_b_pins[2:0];
    assign edgeSel = {q_ff.edgePrio[`IRQ_EP_EDGE2], q_ff.edgePrio[`IRQ_EP_EDGE1],
                      q_ff.edgePrio[`IRQ_EP_EDGE0]};
    assign pinHit = (edgeSel & pinNow & ~q_ff.pinPrev)
                  | (~edgeSel & ~pinNow & q_ff.pinPrev);
    assign portHit = (port_b_pins[7:4] ^ q_ff.portPrev) & q_ff.pinEn[7:4];
    assign t0Roll = timerTick && (q_ff.timerWide ? (q_ff.timerZero == 16'hFFFF)
                                                 : (q_ff.timerZero[7:0] == 8'hFF));

    // Request gating and priority classification.
    assign xFlag = {q_ff.extPins[`IRQ_XP_X2F], q_ff.extPins[`IRQ_XP_X1F],
                    q_ff.main[`IRQ_MAIN_X0F]};
    assign xEn = {q_ff.extPins[`IRQ_XP_X2E], q_ff.extPins[`IRQ_XP_X1E],
                  q_ff.main[`IRQ_MAIN_X0E]};
    // Pin 0 is fixed high; the other two read their own bits.
    assign xPrio = {q_ff.extPins[`IRQ_XP_X2P], q_ff.extPins[`IRQ_XP_X1P], 1'b1};
    assign xReq = xFlag & xEn;
    assign t0Req = q_ff.main[`IRQ_MAIN_T0F] & q_ff.main[`IRQ_MAIN_T0E];
    assign pcReq = q_ff.main[`IRQ_MAIN_PCF] & q_ff.main[`IRQ_MAIN_PCE];
    assign prioOn = q_ff.causePrio[`IRQ_RC_PRIO_EN];
    assign globalEn = q_ff.main[`IRQ_MAIN_GLOBAL_EN];
    assign periEn = q_ff.main[`IRQ_MAIN_PERI_EN];
    assign anyHigh = prioOn && (|(xReq & xPrio)
                   || (t0Req && q_ff.edgePrio[`IRQ_EP_T0P])
                   || (pcReq && q_ff.edgePrio[`IRQ_EP_PCP]));
    assign anyLow = prioOn ? (|(xReq & ~xPrio)
                   || (t0Req && !q_ff.edgePrio[`IRQ_EP_T0P])
                   || (pcReq && !q_ff.edgePrio[`IRQ_EP_PCP]))
                   : (|xReq || t0Req || pcReq);
    // Without priority mode every source uses the low path and one global enable.
    assign takeHigh = anyHigh && globalEn && (q_ff.svc != irq_src_pkg::SERVE_HIGH);
    assign takeLow = anyLow && !anyHigh && (q_ff.svc == irq_src_pkg::RUN)
                   && (prioOn ? (globalEn && periEn) : globalEn);

    // Next-state logic for registers, detectors, timer and service tracking.
    always_comb begin
        nxt_q = q_ff;
        nxt_q.pinPrev = pinNow;
        nxt_q.portPrev = port_b_pins[7:4];
        nxt_q.pushStrobe = 1'b0;
        nxt_q.rdData = 8'h00;
        if (timerTick) begin
            nxt_q.timerZero = q_ff.timerWide ? q_ff.timerZero + 16'h0001
                            : {8'h00, q_ff.timerZero[7:0] + 8'h01};
        end
        // Software writes come first so that hardware sets below win.
        if (regWrite) begin
            case (regAddr)
                `IRQ_OFS_MAIN: nxt_q.main = regWrData;
                `IRQ_OFS_EDGE_PRIO: nxt_q.edgePrio = regWrData & `IRQ_MASK_EDGE_PRIO;
                `IRQ_OFS_EXT_PINS: nxt_q.extPins = regWrData & `IRQ_MASK_EXT_PINS;
                `IRQ_OFS_PIN_EN: nxt_q.pinEn = regWrData & `IRQ_MASK_PIN_EN;
                `IRQ_OFS_PRIO4: nxt_q.prio4 = regWrData & `IRQ_MASK_PRIO;
                `IRQ_OFS_PRIO5: nxt_q.prio5 = regWrData & `IRQ_MASK_PRIO;
                `IRQ_OFS_CAUSE_PRIO: nxt_q.causePrio = regWrData & `IRQ_MASK_CAUSE_PRIO;
                `IRQ_OFS_TMR_LO: nxt_q.timerZero[7:0] = regWrData;
                `IRQ_OFS_TMR_HI: nxt_q.timerZero[15:8] = regWrData;
                `IRQ_OFS_TMR_CTL: nxt_q.timerWide = regWrData[0];
                default: ;
            endcase
        end
        // Hardware flag sets; only the port change flag heeds its pin enables, and flags hold until written.
        if (pinHit[0]) nxt_q.main[`IRQ_MAIN_X0F] = 1'b1;
        if (pinHit[1]) nxt_q.extPins[`IRQ_XP_X1F] = 1'b1;
        if (pinHit[2]) nxt_q.extPins[`IRQ_XP_X2F] = 1'b1;
        if (t0Roll) nxt_q.main[`IRQ_MAIN_T0F] = 1'b1;
        if (|portHit) nxt_q.main[`IRQ_MAIN_PCF] = 1'b1;
        // Sleep records which pin enables were armed before entry.
        if (sleepEnter && !q_ff.asleep) begin
            nxt_q.asleep = 1'b1;
            nxt_q.enAtSleep = xEn;
        end else if (q_ff.asleep && |(xFlag & q_ff.enAtSleep)) begin
            nxt_q.asleep = 1'b0;
        end
        // Service tracking; high entry may preempt a low routine.
        case (q_ff.svc)
            irq_src_pkg::RUN,
            irq_src_pkg::SERVE_LOW: begin
                if (takeHigh) begin
                    nxt_q.svc = irq_src_pkg::SERVE_HIGH;
                end else if (takeLow) begin
                    nxt_q.svc = irq_src_pkg::SERVE_LOW;
                end
            end
            irq_src_pkg::SERVE_HIGH: begin
                if (retFromIrq) nxt_q.svc = irq_src_pkg::RUN;
            end
            default: nxt_q.svc = irq_src_pkg::RUN;
        endcase
        if (q_ff.svc == irq_src_pkg::SERVE_LOW && retFromIrq && !takeHigh) begin
            nxt_q.svc = irq_src_pkg::RUN;
        end
        // Entry saves the return address and the fast context.
        if (takeHigh || takeLow) begin
            nxt_q.retPc = corePc;
            nxt_q.pushStrobe = 1'b1;
            nxt_q.fastCtx = coreCtx;
        end
        if (regRead) begin
            case (regAddr)
                `IRQ_OFS_MAIN: nxt_q.rdData = q_ff.main;
                `IRQ_OFS_EDGE_PRIO: nxt_q.rdData = q_ff.edgePrio;
                `IRQ_OFS_EXT_PINS: nxt_q.rdData = q_ff.extPins;
                `IRQ_OFS_PIN_EN: nxt_q.rdData = q_ff.pinEn;
                `IRQ_OFS_PRIO4: nxt_q.rdData = q_ff.prio4;
                `IRQ_OFS_PRIO5: nxt_q.rdData = q_ff.prio5;
                `IRQ_OFS_CAUSE_PRIO: nxt_q.rdData = q_ff.causePrio;
                `IRQ_OFS_TMR_LO: nxt_q.rdData = q_ff.timerZero[7:0];
                `IRQ_OFS_TMR_HI: nxt_q.rdData = q_ff.timerZero[15:8];
                `IRQ_OFS_TMR_CTL: nxt_q.rdData = {7'h00, q_ff.timerWide};
                `IRQ_OFS_CTX_W: nxt_q.rdData = q_ff.fastCtx.working;
                `IRQ_OFS_CTX_S: nxt_q.rdData = q_ff.fastCtx.status;
                `IRQ_OFS_CTX_B: nxt_q.rdData = q_ff.fastCtx.bank;
                default: nxt_q.rdData = 8'h00;
            endcase
        end
    end

    // State register; reset clears the pin samples to zero, so they do not start from the live pins.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q_ff <= '0;
            q_ff.edgePrio <= `IRQ_RST_EDGE_PRIO;
            q_ff.extPins <= `IRQ_RST_EXT_PINS;
            q_ff.pinEn <= `IRQ_RST_PIN_EN;
            q_ff.svc <= irq_src_pkg::RUN;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Outputs; vectors are taken only with the global enable, even after a wake.
    assign regRdData = q_ff.rdData;
    assign wakeUp = q_ff.asleep && |(xFlag & q_ff.enAtSleep);
    assign vectorHigh = takeHigh;
    assign vectorLow = takeLow;
    assign stackPushPc = q_ff.retPc;
    assign stackPush = q_ff.pushStrobe;
    assign highReq = anyHigh;
    assign lowReq = anyLow;
    assign capcmpPrio = q_ff.prio4[2:0];
    assign timerPrio = q_ff.prio5[2:0];

    AST_EDGE_SETS_FLAG: assert property (@(posedge core_clk) disable iff (rst)
        pinHit[0] |=> q_ff.main[`IRQ_MAIN_X0F])
        else $error("Pin 0 edge did not set its flag.");
    AST_FALL_EDGE: assert property (@(posedge core_clk) disable iff (rst)
        (!edgeSel[1] && q_ff.pinPrev[1] && !pinNow[1]) |=> q_ff.extPins[`IRQ_XP_X1F])
        else $error("Falling edge on pin 1 missed.");
    AST_ENABLE_GATES: assert property (@(posedge core_clk) disable iff (rst)
        (!xEn[1] && !xEn[0] && !xEn[2] && !t0Req && !pcReq) |-> !vectorHigh && !vectorLow)
        else $error("Vector taken with all sources disabled.");
    AST_GLOBAL_GATES: assert property (@(posedge core_clk) disable iff (rst)
        !globalEn |-> !vectorHigh && !vectorLow)
        else $error("Vector taken with global enable clear.");
    AST_PIN0_HIGH: assert property (@(posedge core_clk) disable iff (rst)
        (prioOn && xReq[0]) |-> highReq)
        else $error("Pin 0 request not high priority.");
    AST_T0_ROLL8: assert property (@(posedge core_clk) disable iff (rst)
        (timerTick && !q_ff.timerWide && q_ff.timerZero[7:0] == 8'hFF && !regWrite)
        |=> q_ff.main[`IRQ_MAIN_T0F] && q_ff.timerZero[7:0] == 8'h00)
        else $error("8-bit rollover did not set timer flag.");
    AST_T0_ROLL16: assert property (@(posedge core_clk) disable iff (rst)
        (timerTick && q_ff.timerWide && q_ff.timerZero != 16'hFFFF && !regWrite
         && !$past(q_ff.main[`IRQ_MAIN_T0F]) && !q_ff.main[`IRQ_MAIN_T0F])
        |=> !q_ff.main[`IRQ_MAIN_T0F] || $past(regWrite))
        else $error("16-bit timer flag set without rollover.");
    AST_FLAG_STICKY: assert property (@(posedge core_clk) disable iff (rst)
        (q_ff.main[`IRQ_MAIN_PCF] && !regWrite) |=> q_ff.main[`IRQ_MAIN_PCF])
        else $error("Port change flag dropped without a write.");
    AST_CTX_SAVED: assert property (@(posedge core_clk) disable iff (rst)
        (vectorHigh || vectorLow) |=> stackPush && stackPushPc == $past(corePc)
        && q_ff.fastCtx == $past(coreCtx))
        else $error("Context not saved on entry.");
    AST_HIGH_FIRST: assert property (@(posedge core_clk) disable iff (rst)
        (anyHigh && anyLow) |-> !vectorLow)
        else $error("Low request taken ahead of a high one.");
endmodule

/* irq_core_model.sv */
// Stands in for the processor core: it takes vectors and returns from service.
module irq_core_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic vectorHigh,
    input wire logic vectorLow,
    input wire logic [3:0] retDelay,
    output logic [20:0] corePc,
    output irq_src_pkg::ctx_t coreCtx,
    output logic retFromIrq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] svcCnt;
    logic inSvc;

    // The core keeps running, so the address and registers change every cycle.
    // That way a late or early capture in the design shows up as a wrong value.
    // A routine lasts retDelay cycles; a new vector, as in preemption, restarts it.
    always @(posedge core_clk) begin
        retFromIrq <= 1'b0;
        corePc <= corePc + 21'h3;
        coreCtx <= coreCtx + 24'h050301;
        if (rst) begin
            corePc <= 21'h10000;
            coreCtx <= 24'hA51C3E;
            inSvc <= 1'b0;
            svcCnt <= 4'h0;
        end else if (vectorHigh || vectorLow) begin
            inSvc <= 1'b1;
            svcCnt <= 4'h1;
        end else if (inSvc && svcCnt == retDelay) begin
            inSvc <= 1'b0;
            retFromIrq <= 1'b1;
        end else if (inSvc) begin
            svcCnt <= svcCnt + 4'h1;
        end
    end
endmodule

/* irq_sources_tb.sv */
`include "irq_src_defs.svh"

module irq_sources_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] port_b_pins = 8'h00;
    logic timerTick = 1'b0;
    logic sleepEnter = 1'b0;
    logic [3:0] retDelay = 4'h6;
    logic [7:0] regRdData, v, w;
    logic [20:0] corePc, stackPushPc, savedPc;
    irq_src_pkg::ctx_t coreCtx, savedCtx;
    logic retFromIrq, wakeUp, vectorHigh, vectorLow, stackPush, highReq, lowReq;
    logic [2:0] capcmpPrio, timerPrio;
    logic [7:0] rstTab [7] = '{`IRQ_RST_MAIN, `IRQ_RST_EDGE_PRIO, `IRQ_RST_EXT_PINS,
        `IRQ_RST_PIN_EN, `IRQ_RST_PRIO, `IRQ_RST_PRIO, 8'h00};
    int fails = 0;
    int n_compared = 0;
    int nRet = 0;

    irq_sources dut (.core_clk, .rst, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData, .port_b_pins, .timerTick, .sleepEnter, .corePc, .coreCtx, .retFromIrq,
        .wakeUp, .vectorHigh, .vectorLow, .stackPushPc, .stackPush, .highReq, .lowReq,
        .capcmpPrio, .timerPrio);
    irq_core_model core (.core_clk, .rst, .vectorHigh, .vectorLow, .retDelay, .corePc,
        .coreCtx, .retFromIrq);

    // Clock, and a tally of returns so that a quick return is never missed.
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (retFromIrq === 1'b1) nRet++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t ns: got %0h, expected %0h", $time, got, exp);
        end
    endtask

    // Bus cycles: every strobe is one cycle long and read data lands one cycle later.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask
    task automatic pins(input logic [7:0] d);
        @(posedge core_clk);
        port_b_pins <= d;
    endtask
    task automatic tick();
        @(posedge core_clk);
        timerTick <= 1'b1;
        @(posedge core_clk);
        timerTick <= 1'b0;
    endtask
    task automatic snooze();
        @(posedge core_clk);
        sleepEnter <= 1'b1;
        @(posedge core_clk);
        sleepEnter <= 1'b0;
    endtask
    task automatic clearFlags();
        wr(`IRQ_OFS_MAIN, 8'h00);
        wr(`IRQ_OFS_EXT_PINS, 8'hC0);
    endtask

    // The routine clears its flag before the core returns, otherwise it would re-enter.
    task automatic expectVector(input logic hi);
        int i;
        int r0;
        i = 0;
        r0 = nRet;
        // A flag set by the tick that called us already shows its vector now; a pin edge flags one cycle later.
        #1;
        while (vectorHigh !== 1'b1 && vectorLow !== 1'b1 && i < 8) begin
            @(posedge core_clk);
            #1;
            i++;
        end
        chk({vectorHigh, vectorLow, highReq, lowReq}, {hi, !hi, hi, !hi});
        savedPc = corePc;
        savedCtx = coreCtx;
        @(posedge core_clk);
        #1;
        chk({stackPush, stackPushPc}, {1'b1, savedPc});
        clearFlags();
        rd(`IRQ_OFS_CTX_W, savedCtx.working);
        rd(`IRQ_OFS_CTX_S, savedCtx.status);
        rd(`IRQ_OFS_CTX_B, savedCtx.bank);
        i = 0;
        while (nRet == r0 && i < 20) begin
            @(posedge core_clk);
            i++;
        end
        chk(nRet - r0, 1);
    endtask

    task automatic test_done();
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The whole run takes well under a thousand cycles; this cuts a hang short.
    initial begin
        #100us;
        fails++;
        test_done();
    end

    initial begin
        v = 8'($urandom(26327));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        for (int a = 0; a < 7; a++) begin
            rd(4'(a), rstTab[a]);
        end
        rd(4'hD, 8'h00);
        chk({capcmpPrio, timerPrio, highReq, lowReq, wakeUp}, 9'h000);
        $display("test reset done");
        // Random priorities; the upper five bits must read back as zero.
        repeat (6) begin
            v = 8'($urandom());
            w = 8'($urandom());
            wr(`IRQ_OFS_PRIO4, v);
            wr(`IRQ_OFS_PRIO5, w);
            rd(`IRQ_OFS_PRIO4, v & `IRQ_MASK_PRIO);
            rd(`IRQ_OFS_PRIO5, w & `IRQ_MASK_PRIO);
            chk({capcmpPrio, timerPrio}, {v[2:0], w[2:0]});
        end
        $display("test priority done");
        // Each pin sees a rise then a fall; only the selected edge may flag, enables off.
        for (int e = 0; e < 2; e++) begin
            for (int p = 0; p < 3; p++) begin
                wr(`IRQ_OFS_EDGE_PRIO, 8'h85 | (8'(e) << (6 - p)));
                for (int lvl = 1; lvl >= 0; lvl--) begin
                    clearFlags();
                    pins(8'(lvl) << p);
                    w = p == 0 ? 8'(lvl == e) << 1 : 8'hC0 | (8'(lvl == e) << (p - 1));
                    rd(p == 0 ? `IRQ_OFS_MAIN : `IRQ_OFS_EXT_PINS, w);
                    chk({highReq, lowReq}, 2'b00);
                end
            end
        end
        $display("test pin edges done");
        // Timer zero: only the full-width rollover flags, in either mode.
        clearFlags();
        wr(`IRQ_OFS_TMR_LO, 8'hFE);
        tick();
        rd(`IRQ_OFS_MAIN, 8'h00);
        tick();
        rd(`IRQ_OFS_MAIN, 8'h04);
        clearFlags();
        wr(`IRQ_OFS_TMR_CTL, 8'h01);
        wr(`IRQ_OFS_TMR_HI, 8'h00);
        wr(`IRQ_OFS_TMR_LO, 8'hFF);
        tick();
        rd(`IRQ_OFS_MAIN, 8'h00);
        rd(`IRQ_OFS_TMR_HI, 8'h01);
        wr(`IRQ_OFS_TMR_HI, 8'hFF);
        wr(`IRQ_OFS_TMR_LO, 8'hFF);
        tick();
        rd(`IRQ_OFS_MAIN, 8'h04);
        wr(`IRQ_OFS_TMR_CTL, 8'h00);
        $display("test timer done");
        // Port change: a disabled pin is ignored, an enabled one flags on a rising edge.
        clearFlags();
        pins(8'h20);
        rd(`IRQ_OFS_MAIN, 8'h01);
        clearFlags();
        wr(`IRQ_OFS_PIN_EN, 8'h10);
        pins(8'h00);
        rd(`IRQ_OFS_MAIN, 8'h00);
        pins(8'h10);
        rd(`IRQ_OFS_MAIN, 8'h01);
        pins(8'h00);
        wr(`IRQ_OFS_PIN_EN, 8'hF0);
        $display("test port change done");
        // Pin zero vectors low with priority off and high with it on.
        // Then pin one, the timer and the port change with either priority.
        wr(`IRQ_OFS_EDGE_PRIO, 8'hF5);
        for (int h = 0; h < 2; h++) begin
            retDelay <= 4'($urandom_range(15, 6));
            wr(`IRQ_OFS_CAUSE_PRIO, 8'(h) << 7);
            clearFlags();
            wr(`IRQ_OFS_MAIN, 8'h90);
            pins(8'h01);
            expectVector(h[0]);
            pins(8'h00);
        end
        for (int q = 0; q < 2; q++) begin
            retDelay <= 4'($urandom_range(15, 6));
            wr(`IRQ_OFS_EXT_PINS, 8'h88 | (8'(q) << 6));
            wr(`IRQ_OFS_MAIN, 8'hC0);
            pins(8'h02);
            expectVector(q[0]);
            pins(8'h00);
            wr(`IRQ_OFS_EDGE_PRIO, 8'hF1 | (8'(q) << 2));
            wr(`IRQ_OFS_TMR_LO, 8'hFF);
            wr(`IRQ_OFS_MAIN, 8'hE0);
            tick();
            expectVector(q[0]);
            wr(`IRQ_OFS_EDGE_PRIO, 8'hF4 | 8'(q));
            wr(`IRQ_OFS_MAIN, 8'hC8);
            pins(8'h10);
            expectVector(q[0]);
            pins(8'h00);
        end
        $display("test vectors done");
        // An armed pin wakes the core, with no vector while global enable is off.
        // Only a wake ends the sleep, so the unarmed case has to come second.
        wr(`IRQ_OFS_MAIN, 8'h10);
        snooze();
        pins(8'h01);
        @(posedge core_clk);
        #1;
        chk({wakeUp, vectorHigh, vectorLow}, 3'b100);
        clearFlags();
        pins(8'h00);
        snooze();
        wr(`IRQ_OFS_MAIN, 8'h10);
        pins(8'h01);
        rd(`IRQ_OFS_MAIN, 8'h12);
        chk(wakeUp, 1'b0);
        $display("test wake done");
        test_done();
    end
endmodule
